// >>> hw/adc_scan_sequence_config.sv
// Purpose: scan trigger, sequencing, result buffer and reference setup
// Assumes: converter core on ref_clk; trigger pin asynchronous
// Notes:   APB answers with no wait states; result reg read pops
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module adc_scan_sequence_config
	import scan_cfg_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    trigger_network,
	input  wire logic                    result_valid,
	input  wire logic [RES_W-1:0]        result_data,
	output scan_cfg_pkg::conv_req_t      conv,
	output scan_cfg_pkg::ref_cfg_t       refcfg,
	output logic                         acq_req,
	output logic                         warmup_start,
	output logic                         scan_overflow_flag,
	output logic                         data_valid_flag,
	output logic                         irq
);
	import scan_cfg_pkg::*;

	typedef struct packed {
		scan_st_t                    st;
		logic [31:0]                 ctrlx;
		logic [31:0]                 mask;
		logic [31:0]                 insel;
		logic [15:0]                 negative_pick;
		logic [1:0]                  flags;
		logic [2:0]                  mode;
		logic [DEPTH-1:0][RES_W-1:0] mem;
		logic [1:0]                  rp;
		logic [1:0]                  wp;
		logic [2:0]                  cnt;
		logic [4:0]                  idx;
		logic                        did;
		logic                        trigger_length_governs_warmup;
		logic [7:0]                  wcnt;
		logic [1:0]                  div;
		logic                        trig_prev;
		logic [31:0]                 prdata;
		logic                        pready;
		logic                        pslverr;
		logic                        acq_req;
		logic                        warm_start;
		conv_req_t                   conv;
		ref_cfg_t                    refo;
		logic                        irq;
	} state_t;

	state_t     s;
	state_t     n;
	logic       trig_lvl;
	logic       trig_rise;
	logic       trig_fall;
	logic       wr;
	logic       rd;
	logic       pop;
	logic       push;
	logic       full_eff;
	logic [2:0] cnt_n;
	logic [4:0] neg_idx;
	logic [2:0] pos_bus;
	logic [4:0] pos_chan;
	logic [2:0] neg_bus;
	logic [4:0] neg_chan;
	logic [3:0] ref_att;
	logic [2:0] ref_sel;

	pin_sync u_trig_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     (trigger_network),
		.q     (trig_lvl)
	);

	// negative partner of a differential input
	function automatic logic [4:0] neg_of(logic [4:0] p, logic [15:0] ns);
		logic [4:0] r;
		r = p + 5'h01;
		if (p < IN_EIGHT && !p[0]) begin
			r = {2'h0, ns[{p[2:1], 1'b0} +: 2], 1'b1};
		end else if (p > IN_EIGHT && p <= IN_FIFTN && p[0]) begin
			r = {2'h1, ns[{1'b1, p[2:1], 1'b0} +: 2], 1'b0};
		end else if (p == IN_SEVEN) begin
			r = IN_EIGHT;
		end else if (p == IN_LAST) begin
			r = IN_WRAP;
		end
		return r;
	endfunction

	assign neg_idx = neg_of(s.idx, s.negative_pick);

	// one decoder per end of the pair; four groups of eight each
	group_decode u_pos_grp (
		.code (s.insel[{s.idx[4:3], 3'h0} +: 5]),
		.slot (s.idx[2:0]),
		.bus  (pos_bus),
		.chan (pos_chan)
	);

	group_decode u_neg_grp (
		.code (s.insel[{neg_idx[4:3], 3'h0} +: 5]),
		.slot (neg_idx[2:0]),
		.bus  (neg_bus),
		.chan (neg_chan)
	);

	assign trig_rise = trig_lvl && !s.trig_prev;
	assign trig_fall = !trig_lvl && s.trig_prev;
	assign wr  = psel && penable && s.pready && pwrite;
	assign rd  = psel && penable && s.pready && !pwrite;
	assign pop = rd && paddr == OFS_RESULT && s.cnt != 3'h0;
	assign push     = s.st == ST_CONV && result_valid;
	assign full_eff = s.cnt == DEPTH_C && !pop;
	assign ref_att  = s.ctrlx[REFATT_LSB +: 4];
	assign ref_sel  = s.ctrlx[REFSEL_LSB +: 3];

	always_comb begin
		n = s;
		n.pready     = 1'b0;
		n.pslverr    = 1'b0;
		n.acq_req    = 1'b0;
		n.warm_start = 1'b0;
		n.conv.start = 1'b0;
		n.trig_prev  = trig_lvl;
		n.div        = (s.div == DIV_LAST) ? 2'h0 : s.div + 2'h1;
		cnt_n        = s.cnt - {2'h0, pop};

		// setup cycle latches the answer for the access phase
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.prdata = ZERO32;
			if (paddr == OFS_CTRLX) begin
				n.prdata = s.ctrlx;
			end else if (paddr == OFS_MASK) begin
				n.prdata = s.mask;
			end else if (paddr == OFS_INSEL) begin
				n.prdata = s.insel;
			end else if (paddr == OFS_NEGATIVE_PICK) begin
				n.prdata = {16'h0000, s.negative_pick};
			end else if (paddr == OFS_FLAGS) begin
				n.prdata = {29'h0000_0000, s.cnt == 3'h0, s.flags};
			end else if (paddr == OFS_MODE) begin
				n.prdata = {29'h0000_0000, s.mode};
			end else if (paddr == OFS_RESULT) begin
				n.prdata = {16'h0000, s.mem[s.rp]};
			end else begin
				n.pslverr = 1'b1;
			end
		end

		// reserved bits are masked so they always read zero
		if (wr) begin
			if (paddr == OFS_CTRLX) begin
				n.ctrlx = pwdata & CTRLX_WMASK;
			end else if (paddr == OFS_MASK) begin
				n.mask = pwdata;
			end else if (paddr == OFS_INSEL) begin
				n.insel = pwdata & INSEL_WMASK;
			end else if (paddr == OFS_NEGATIVE_PICK) begin
				n.negative_pick = pwdata[15:0];
			end else if (paddr == OFS_FLAGS) begin
				n.flags = s.flags & ~pwdata[1:0];
			end else if (paddr == OFS_MODE) begin
				n.mode = pwdata[2:0];
			end
		end

		case (s.st)
			ST_IDLE: begin
				n.idx = 5'h00;
				n.did = 1'b0;
				if (trig_rise) begin
					n.trigger_length_governs_warmup = s.ctrlx[TRIG_STYLE_BIT];
					if (s.ctrlx[TRIG_STYLE_BIT]) begin
						n.st = ST_HOLD;
					end else begin
						n.st         = ST_WARM;
						n.wcnt       = 8'h00;
						n.warm_start = 1'b1;
						// restart the tick so a partial first one never shortens warm-up
						n.div        = 2'h0;
					end
				end
			end
			ST_WARM: begin
				// warm-up counts converter clock ticks, not ref_clk
				if (s.div == DIV_LAST) begin
					n.wcnt = s.wcnt + 8'h01;
					if (s.wcnt == WARM_LAST) begin
						n.acq_req = 1'b1;
						n.st      = ST_SEEK;
					end
				end
			end
			ST_HOLD: begin
				if (trig_fall) begin
					n.acq_req = 1'b1;
					n.st      = ST_SEEK;
				end
			end
			ST_SEEK: begin
				if ((s.mask >> s.idx) == ZERO32) begin
					if (s.mask == ZERO32 && !s.did) begin
						n.conv.start = 1'b1;
						n.st         = ST_CONV;
					end else begin
						n.st = ST_IDLE;
					end
				end else if (s.mask[s.idx]) begin
					n.conv.start = 1'b1;
					n.st         = ST_CONV;
				end else begin
					n.idx = s.idx + 5'h01;
				end
				n.conv.differential_select     = s.mode[MODE_DIFFERENTIAL_SELECT];
				n.conv.pos      = s.idx;
				n.conv.neg      = s.mode[MODE_DIFFERENTIAL_SELECT] ? neg_idx : s.idx;
				n.conv.pos_bus  = pos_bus;
				n.conv.pos_chan = pos_chan;
				n.conv.neg_bus  = neg_bus;
				n.conv.neg_chan = neg_chan;
			end
			ST_CONV: begin
				if (result_valid) begin
					n.did = 1'b1;
					if (s.idx == IN_LAST) begin
						n.st = ST_IDLE;
					end else begin
						n.idx = s.idx + 5'h01;
						n.st  = ST_SEEK;
					end
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		if (pop) begin
			n.rp = s.rp + 2'h1;
		end
		// hardware sets come after the software clear, so they win
		if (push) begin
			if (!full_eff) begin
				n.mem[s.wp] = result_data;
				n.wp        = s.wp + 2'h1;
				cnt_n       = cnt_n + 3'h1;
				if (cnt_n >= {1'b0, s.ctrlx[DVL_LSB +: 2]} + 3'h1) begin
					n.flags[FLAG_DV] = 1'b1;
				end
			end else begin
				n.flags[FLAG_OVF] = 1'b1;
				if (s.ctrlx[OVF_ACT_BIT]) begin
					n.mem[s.wp] = result_data;
					n.wp        = s.wp + 2'h1;
					n.rp        = s.rp + 2'h1;
				end
			end
		end
		n.cnt = cnt_n;

		n.refo.sel     = ref_sel;
		n.refo.vin_att = s.ctrlx[INPUT_ATTENUATION_CODE_LSB +: 4];
		n.refo.att     = 4'h0;
		n.refo.fixed   = FIX_NONE;
		if (s.ctrlx[FIX_BIT]) begin
			n.refo.fixed = (ref_att == 4'h0) ? FIX_QUARTER : FIX_THIRD;
		end else if (ref_sel == REF_SCALED_SUPPLY || ref_sel == REF_SCALED_SINGLE
			|| ref_sel == REF_SCALED_DIFFERENTIAL_SELECT) begin
			n.refo.att = ref_att;
		end
		n.irq = |(n.flags & s.mode[MODE_EN_DV:MODE_EN_OVF]);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s        <= '0;
			s.st     <= ST_IDLE;
			s.negative_pick <= NEGATIVE_PICK_RST;
		end else begin
			s <= n;
		end
	end

	assign prdata             = s.prdata;
	assign pready             = s.pready;
	assign pslverr            = s.pslverr;
	assign conv               = s.conv;
	assign refcfg             = s.refo;
	assign acq_req            = s.acq_req;
	assign warmup_start       = s.warm_start;
	assign scan_overflow_flag = s.flags[FLAG_OVF];
	assign data_valid_flag    = s.flags[FLAG_DV];
	assign irq                = s.irq;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence pulse_trig_s;
		s.st == ST_IDLE && trig_rise && !s.ctrlx[TRIG_STYLE_BIT];
	endsequence
	sequence overflow_s;
		push && full_eff;
	endsequence

	warm_start_a: assert property (
		pulse_trig_s |=> s.st == ST_WARM && s.warm_start)
		else $error("trigger_async_pulse trigger did not start warm-up");
	trigger_length_governs_warmup_fall_a: assert property (
		s.st == ST_HOLD && trig_fall |=> s.acq_req ##1 !s.acq_req)
		else $error("falling trigger edge did not request acquisition");
	discard_full_a: assert property (
		(overflow_s and !s.ctrlx[OVF_ACT_BIT])
		|=> s.flags[FLAG_OVF] && $stable(s.wp) && s.cnt == DEPTH_C)
		else $error("discard mode stored a result into a full buffer");
	replace_old_a: assert property (
		(overflow_s and s.ctrlx[OVF_ACT_BIT])
		|=> s.flags[FLAG_OVF] && s.rp != $past(s.rp)
		&& s.cnt == DEPTH_C)
		else $error("replace mode did not drop the oldest result");
	dv_level_a: assert property (
		push && !full_eff && cnt_n > {1'b0, s.ctrlx[DVL_LSB +: 2]}
		|=> s.flags[FLAG_DV])
		else $error("data-valid flag missing at threshold");
	ref_gate_a: assert property (
		!s.ctrlx[FIX_BIT] && ref_sel != REF_SCALED_SUPPLY
		&& ref_sel != REF_SCALED_SINGLE && ref_sel != REF_SCALED_DIFFERENTIAL_SELECT
		|=> s.refo.att == 4'h0)
		else $error("reference attenuation applied to unscaled source");
	fix_scale_a: assert property (
		s.ctrlx[FIX_BIT] |=> s.refo.fixed
		== (($past(ref_att) == 4'h0) ? FIX_QUARTER : FIX_THIRD))
		else $error("fixed reference scaling factor wrong");
	empty_mask_a: assert property (
		s.st == ST_SEEK && s.mask == ZERO32 && !s.did
		|=> s.conv.start ##1 s.st == ST_CONV)
		else $error("empty mask did not convert once");
	differential_select_pair_a: assert property (
		s.conv.start && s.conv.differential_select && s.conv.pos == IN_SEVEN
		|-> s.conv.neg == IN_EIGHT)
		else $error("input seven not paired with eight");
endmodule

// >>> hw/group_decode.sv
// Purpose: map a group select code and slot to bus and channel
// Assumes: unlisted codes fall back to bus 0 lower eight
// Notes:   purely combinational
`timescale 1ns/1ps
module group_decode
	import scan_cfg_pkg::*;
(
	input  wire logic [4:0] code,
	input  wire logic [2:0] slot,
	output logic      [2:0] bus,
	output logic      [4:0] chan
);
	always_comb begin
		bus  = 3'h0;
		chan = {2'h0, slot};
		if (code == GRP_B0_HI) begin
			chan = {2'h1, slot};
		end else if (code[4:2] == GRP_B1) begin
			bus  = 3'h1;
			chan = {code[1:0], slot};
		end else if (code == GRP_B2) begin
			bus = 3'h2;
		end else if (code == GRP_B3) begin
			bus = 3'h3;
		end else if (code == GRP_B4) begin
			bus = 3'h4;
		end
	end
endmodule

// >>> hw/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d is asynchronous to clk
// Notes:   q moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic q_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q_q  <= 1'b0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q_q <= s3_q;
			end
		end
	end

	assign q = q_q;
endmodule

// >>> hw/scan_cfg_pkg.sv
// Purpose: shared constants and carriers for the scan configuration block
// Assumes: 50 MHz ref_clk, APB slave with 32-bit data
// Notes:   all offsets are byte addresses
package scan_cfg_pkg;
	localparam int CLK_NS    = 20;
	localparam int CONV_DIV  = 4;
	localparam int CONV_NS   = CLK_NS * CONV_DIV;
	localparam int WARMUP_NS = 5000;
	// least time, so round up to whole converter cycles
	localparam int WARM_CYC  = (WARMUP_NS + CONV_NS - 1) / CONV_NS;
	localparam logic [7:0] WARM_LAST = 8'(WARM_CYC - 1);
	localparam logic [1:0] DIV_LAST  = 2'(CONV_DIV - 1);

	localparam logic [11:0] OFS_CTRLX  = 12'h01C;
	localparam logic [11:0] OFS_MASK   = 12'h020;
	localparam logic [11:0] OFS_INSEL  = 12'h024;
	localparam logic [11:0] OFS_NEGATIVE_PICK = 12'h028;
	localparam logic [11:0] OFS_FLAGS  = 12'h02C;
	localparam logic [11:0] OFS_MODE   = 12'h030;
	localparam logic [11:0] OFS_RESULT = 12'h034;

	localparam logic [31:0] CTRLX_WMASK  = 32'h0001_7FFF;
	localparam logic [31:0] INSEL_WMASK  = 32'h1F1F_1F1F;
	localparam logic [15:0] NEGATIVE_PICK_RST   = 16'h39E4;
	localparam logic [31:0] ZERO32       = 32'h0000_0000;

	localparam int TRIG_STYLE_BIT = 16;
	localparam int OVF_ACT_BIT    = 14;
	localparam int DVL_LSB        = 12;
	localparam int INPUT_ATTENUATION_CODE_LSB     = 8;
	localparam int REFATT_LSB     = 4;
	localparam int FIX_BIT        = 3;
	localparam int REFSEL_LSB     = 0;
	localparam int FLAG_OVF       = 0;
	localparam int FLAG_DV        = 1;
	localparam int MODE_DIFFERENTIAL_SELECT      = 0;
	localparam int MODE_EN_OVF    = 1;
	localparam int MODE_EN_DV     = 2;

	localparam logic [2:0] REF_SCALED_SUPPLY = 3'h1;
	localparam logic [2:0] REF_SCALED_SINGLE = 3'h2;
	localparam logic [2:0] REF_SCALED_DIFFERENTIAL_SELECT   = 3'h5;
	localparam logic [1:0] FIX_NONE    = 2'h0;
	localparam logic [1:0] FIX_QUARTER = 2'h1;
	localparam logic [1:0] FIX_THIRD   = 2'h2;

	localparam logic [4:0] GRP_B0_LO = 5'h00;
	localparam logic [4:0] GRP_B0_HI = 5'h01;
	localparam logic [2:0] GRP_B1    = 3'h1;
	localparam logic [4:0] GRP_B2    = 5'h08;
	localparam logic [4:0] GRP_B3    = 5'h0C;
	localparam logic [4:0] GRP_B4    = 5'h10;

	localparam logic [4:0] IN_LAST   = 5'h1F;
	localparam logic [4:0] IN_SEVEN  = 5'h07;
	localparam logic [4:0] IN_EIGHT  = 5'h08;
	localparam logic [4:0] IN_WRAP   = 5'h18;
	localparam logic [4:0] IN_FIFTN  = 5'h0F;

	localparam int         RES_W   = 16;
	localparam int         DEPTH   = 4;
	localparam logic [2:0] DEPTH_C = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE, ST_WARM, ST_HOLD, ST_SEEK, ST_CONV
	} scan_st_t;

	typedef struct packed {
		logic       start;
		logic       differential_select;
		logic [4:0] pos;
		logic [4:0] neg;
		logic [2:0] pos_bus;
		logic [4:0] pos_chan;
		logic [2:0] neg_bus;
		logic [4:0] neg_chan;
	} conv_req_t;

	typedef struct packed {
		logic [2:0] sel;
		logic [3:0] att;
		logic [1:0] fixed;
		logic [3:0] vin_att;
	} ref_cfg_t;
endpackage

// >>> verif/adc_scan_sequence_config_test.sv
// Purpose: register and scan sequencing checks over APB
// Assumes: APB answers within 40 cycles; result reads pop
// Notes:   expected tables are written out by hand
`timescale 1ns/1ps
module adc_scan_sequence_config_test;
	import scan_cfg_pkg::*;
	logic             ref_clk;
	logic             rst_n;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [11:0]      paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             trigger_network;
	logic             result_valid;
	logic [RES_W-1:0] result_data;
	conv_req_t        conv;
	ref_cfg_t         refcfg;
	logic             acq_req;
	logic             warmup_start;
	logic             scan_overflow_flag;
	logic             data_valid_flag;
	logic             irq;
	logic [3:0]       lag;
	logic [1:0]       fx;
	logic [31:0]      rd_q;
	logic             err_q;
	logic             trig_q;
	int               done_cnt;
	int               mismatches;
	int               cmp_count;
	int               cyc;
	int               warm_at;
	int               acq_at;
	int               fall_at;
	conv_req_t        seen[$];
	logic [12:0]      mexp[2][4];
	logic [10:0]      pexp[5];
	logic [31:0]      ins[2];

	adc_scan_sequence_config u_dut (.ref_clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.trigger_network, .result_valid, .result_data, .conv, .refcfg,
		.acq_req, .warmup_start, .scan_overflow_flag, .data_valid_flag,
		.irq);
	conv_core_model u_part (.ref_clk, .rst_n, .conv, .lag, .result_valid,
		.result_data, .trigger_network, .done_cnt);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		trig_q <= trigger_network;
		if (warmup_start === 1'b1) warm_at <= cyc;
		if (acq_req === 1'b1) acq_at <= cyc;
		if (trig_q === 1'b1 && trigger_network === 1'b0) fall_at <= cyc;
		if (conv.start === 1'b1) seen.push_back(conv);
		if (cyc == 30000) begin
			mismatches++;
			summarize();
		end
	end

	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 40) chk("pready", 1, 0);
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, ZERO32);
		chk(nm, e, rd_q);
	endtask

	task automatic pop(input int n, input int first, input int step,
		input bit check);
		for (int i = 0; i < n; i++) begin
			apb(1'b0, OFS_RESULT, ZERO32);
			if (check) chk("result", 32'hC000 + 32'(first + i * step), rd_q);
		end
	endtask

	task automatic do_scan(input logic trigger_length_governs_warmup, input int n);
		int base;
		int k;
		int span;
		base = done_cnt;
		k = 0;
		seen.delete();
		u_part.fire(trigger_length_governs_warmup);
		while (done_cnt < base + n && k < 2000) begin
			@(posedge ref_clk);
			k++;
		end
		repeat (4) @(posedge ref_clk);
		chk("conversions", n, seen.size());
		span = trigger_length_governs_warmup ? acq_at - fall_at : (acq_at - warm_at) * CLK_NS;
		if (trigger_length_governs_warmup) chk("acq after fall", 1, span > 0 && span <= 8);
		else chk("warm-up", 1, span >= WARMUP_NS
			&& span <= WARMUP_NS + 3 * CONV_NS);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{mismatches, cmp_count} = '0;
		lag = 4'h1;
		rst_n = 1'b0;
		mexp = '{'{{5'h07, 3'h1, 5'h0F}, {5'h08, 3'h2, 5'h00},
			{5'h10, 3'h3, 5'h00}, {5'h1F, 3'h4, 5'h07}},
			'{{5'h07, 3'h1, 5'h07}, {5'h08, 3'h1, 5'h10},
			{5'h10, 3'h0, 5'h08}, {5'h1F, 3'h1, 5'h1F}}};
		pexp = '{{1'b1, 5'h00, 5'h07}, {1'b1, 5'h01, 5'h02},
			{1'b1, 5'h07, 5'h08}, {1'b1, 5'h09, 5'h0A},
			{1'b1, 5'h1F, 5'h18}};
		ins = '{32'h100C_0805, 32'h0701_0604};
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rchk("mask rst", OFS_MASK, ZERO32);
		rchk("insel rst", OFS_INSEL, ZERO32);
		rchk("ctrlx rst", OFS_CTRLX, ZERO32);
		rchk("negative_pick rst", OFS_NEGATIVE_PICK, {16'h0000, NEGATIVE_PICK_RST});
		apb(1'b0, 12'h0FC, ZERO32);
		chk("unmapped", 1, err_q);
		wr(OFS_MASK, 32'hFFFF_FFFF);
		rchk("mask rw", OFS_MASK, 32'hFFFF_FFFF);
		for (int s = 0; s < 8; s++) begin
			for (int f = 0; f < 2; f++) begin
				wr(OFS_CTRLX, 32'({4'(7 - s), 4'(s), 1'(f), 3'(s)}));
				// refcfg follows the control word one edge after the write
				@(posedge ref_clk);
				fx = f == 0 ? FIX_NONE : (s == 0 ? FIX_QUARTER : FIX_THIRD);
				chk("refcfg", {3'(s), fx, 4'(7 - s)},
					{refcfg.sel, refcfg.fixed, refcfg.vin_att});
				if (f == 0 && (s == 1 || s == 2 || s == 5))
					chk("ref att", s, refcfg.att);
				else chk("ref att", 0, refcfg.att);
			end
		end
		wr(OFS_MODE, 32'h0000_0004);
		wr(OFS_CTRLX, 32'h0000_1000);
		wr(OFS_MASK, 32'h0000_0001);
		do_scan(1'b0, 1);
		chk("dv early", 0, data_valid_flag);
		do_scan(1'b0, 1);
		chk("dv level", 1, data_valid_flag);
		chk("irq dv", 1, irq);
		wr(OFS_FLAGS, 32'h0000_0003);
		rchk("flags clr", OFS_FLAGS, ZERO32);
		chk("irq clr", 0, irq);
		pop(2, 0, 0, 1);
		wr(OFS_MODE, 32'h0000_0002);
		wr(OFS_CTRLX, ZERO32);
		wr(OFS_MASK, 32'h0000_001F);
		do_scan(1'b0, 5);
		chk("ovf discard", 1, scan_overflow_flag);
		chk("irq ovf", 1, irq);
		pop(4, 0, 1, 1);
		rchk("empty", OFS_FLAGS, 32'h0000_0007);
		wr(OFS_FLAGS, 32'h0000_0003);
		wr(OFS_CTRLX, 32'h0001_4000);
		lag = 4'h5;
		do_scan(1'b1, 5);
		chk("ovf replace", 1, scan_overflow_flag);
		pop(4, 1, 1, 1);
		wr(OFS_FLAGS, 32'h0000_0003);
		wr(OFS_CTRLX, ZERO32);
		lag = 4'h1;
		wr(OFS_MASK, 32'h8001_0180);
		for (int t = 0; t < 2; t++) begin
			wr(OFS_INSEL, ins[t]);
			do_scan(1'b0, 4);
			for (int i = 0; i < 4; i++)
				chk("map", mexp[t][i], {seen[i].pos, seen[i].pos_bus,
					seen[i].pos_chan});
			pop(4, 0, 0, 0);
		end
		wr(OFS_MODE, 32'h0000_0001);
		wr(OFS_NEGATIVE_PICK, 32'h0000_39E7);
		wr(OFS_MASK, 32'h8000_0283);
		do_scan(1'b0, 5);
		for (int i = 0; i < 5; i++)
			chk("pair", pexp[i], {seen[i].differential_select, seen[i].pos,
				seen[i].neg});
		chk("neg map", {3'h1, 5'h07}, {seen[0].neg_bus, seen[0].neg_chan});
		pop(4, 0, 0, 0);
		wr(OFS_FLAGS, 32'h0000_0003);
		wr(OFS_MODE, ZERO32);
		wr(OFS_MASK, ZERO32);
		do_scan(1'b0, 1);
		chk("empty mask", 0, seen.size() > 0 ? seen[0].pos : 5'h1F);
		summarize();
	end
endmodule

// >>> verif/conv_core_model.sv
// Purpose: converter core and trigger source on the block's far side
// Assumes: one result lag+1 cycles after each conversion start
// Notes:   result bus toggles whenever no result is offered
`timescale 1ns/1ps
module conv_core_model (
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	input  wire scan_cfg_pkg::conv_req_t          conv,
	input  wire logic [3:0]                       lag,
	output logic                                  result_valid,
	output logic [scan_cfg_pkg::RES_W-1:0]        result_data,
	output logic                                  trigger_network,
	output int                                    done_cnt
);
	import scan_cfg_pkg::*;
	logic [3:0] wait_q;
	logic       busy_q;

	initial trigger_network = 1'b0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
			result_valid <= 1'b0;
			result_data <= 16'hFFFF;
			done_cnt <= 0;
		end else if (busy_q && wait_q == 4'h0) begin
			busy_q <= 1'b0;
			result_valid <= 1'b1;
			result_data <= 16'hC000 | 16'(conv.pos);
			done_cnt <= done_cnt + 1;
		end else begin
			// never leave a stale result on the bus
			result_valid <= 1'b0;
			result_data <= ~result_data;
			if (conv.start) begin
				busy_q <= 1'b1;
				wait_q <= lag;
			end else if (busy_q) begin
				wait_q <= wait_q - 4'h1;
			end
		end
	end

	// short pulse, or a high phase long enough to span the warm-up
	task automatic fire(input logic trigger_length_governs_warmup);
		@(posedge ref_clk);
		trigger_network <= 1'b1;
		repeat (trigger_length_governs_warmup ? WARM_CYC * CONV_DIV + 8 : 6) @(posedge ref_clk);
		trigger_network <= 1'b0;
	endtask
endmodule
